// ---- verilog/hpc_pkg.sv ----
// Shared constants and types for the host port control pins.
`default_nettype none
package hpc_pkg;
    localparam int CLK_HZ = 25000000;
    // Least controller reset pulse, in microseconds.
    localparam int RESET_MIN_US = 2000;
    localparam int RESET_MIN_CYC = (CLK_HZ / 1000000) * RESET_MIN_US;
    localparam int CNT_W = 17;
    // Reset recovery lengths, in cycles, for power-up and warm resets.
    localparam logic [CNT_W-1:0] COLD_RECOVERY_CYC = 17'h00400;
    localparam logic [CNT_W-1:0] WARM_RECOVERY_CYC = 17'h00010;
    // Default serial format forced by the baud default select pin.
    localparam logic [23:0] DEFAULT_BAUD = 24'h002580;
    localparam logic [3:0] DEFAULT_DATA_BITS = 4'h8;
    localparam logic [1:0] DEFAULT_PARITY = 2'h0;
    localparam logic [1:0] DEFAULT_STOP_BITS = 2'h1;
    typedef enum logic [1:0] {
        HPC_COLD = 2'b00,
        HPC_RUN = 2'b01,
        HPC_RESET = 2'b10,
        HPC_WARM = 2'b11
    } hpc_state_e;
    typedef enum logic [1:0] {
        HPC_H_IDLE = 2'b00,
        HPC_H_PULSE = 2'b01
    } hpc_hstate_e;
endpackage
`default_nettype wire

// ---- verilog/hpc_if.sv ----
// Control pins between the transceiver and its host.
`default_nettype none
interface hpc_if;
    logic cts_n;
    logic rts_n;
    logic baud_default_select;
    logic nvm_write_permit;
    logic ctrl_reset;
    logic ctrl_reset_oe;
    logic ctrl_reset_dev;
    logic ctrl_reset_dev_oe;
    modport device (
        output cts_n,
        input rts_n,
        input baud_default_select,
        input nvm_write_permit,
        input ctrl_reset,
        output ctrl_reset_dev,
        output ctrl_reset_dev_oe
    );
    modport host (
        input cts_n,
        output rts_n,
        output baud_default_select,
        output nvm_write_permit,
        output ctrl_reset,
        output ctrl_reset_oe
    );
endinterface
`default_nettype wire

// ---- verilog/hpc_device.sv ----
// Transceiver end of the host control pins.
//
// Contract
// - Clear-to-send low while transmit data accepted.
// - Select low forces 9600 baud, 8-N-1.
// - Host drives request-to-send low when ready.
// - Memory writes allowed only while permit low.
// - Host keeps permit high during power-up, reset.
// - Reset high at least 2ms resets device.
// - Warm reset completes much faster than cold.
// - Host holds reset low otherwise.
// - Device pulls unconnected reset input low.
// - Baud select sampled at reset release.
//
// Behaviour
// Each host pin passes two flops, so a pin change shows at the registered
// outputs three clock edges later.
// The asynchronous reset starts a cold recovery; a host reset pulse that
// meets the least width starts the much shorter warm recovery.
// The pulse is counted one synchronised sample at a time, the first high
// sample included, so a pulse of exactly the least width is accepted.
// Once the count is met the block enters reset while the pin is still
// high, and recovery starts when the pin falls.
// A shorter pulse is ignored while the block runs, but a shorter pulse
// during a recovery starts a cold recovery.
// The serial format is latched once, as recovery ends, and is held until
// the next reset.
// While in reset, clear-to-send stays high and memory writes are blocked.
// The block holds the reset pin low through a weak pull, so a pin left
// unconnected by the host never resets it.
// Recovery lengths are package constants chosen for this block.
`default_nettype none
module hpc_device (
    input wire logic clk_in,
    input wire logic arst_n_in,
    hpc_if.device pins,
    input wire logic tx_space_in,
    input wire logic nvm_write_req_in,
    input wire logic [23:0] nvm_baud_in,
    output logic nvm_write_out,
    output logic nvm_write_blocked_out,
    output logic host_ready_out,
    output logic in_reset_out,
    output logic [23:0] baud_out,
    output logic [3:0] data_bits_out,
    output logic [1:0] parity_out,
    output logic [1:0] stop_bits_out
);
    typedef struct packed {
        // Synchroniser stages, the older sample in bit 1.
        logic [1:0] rts_s;
        logic [1:0] bds_s;
        logic [1:0] wp_s;
        logic [1:0] rst_s;

        // Reset sequencing and pulse counting.
        hpc_pkg::hpc_state_e state;
        logic [hpc_pkg::CNT_W-1:0] cnt;

        // Registered pin and handshake outputs.
        logic cts_n;
        logic wr;
        logic blk;
        logic rdy;
        logic in_rst;
        logic pull_lo;
        logic pull_oe;

        // Serial format latched as recovery ends.
        logic [23:0] baud;
        logic [3:0] dbits;
        logic [1:0] par;
        logic [1:0] stop;
    } hpc_dev_s;

    hpc_dev_s r;
    hpc_dev_s next_r;
    logic pulse_ok;

    // The reset counter saturates once the least pulse is met.
    // It holds its count while the pin stays high past the least width.
    assign pulse_ok = r.cnt >= hpc_pkg::CNT_W'(hpc_pkg::RESET_MIN_CYC);

    always_comb begin
        next_r = r;

        // Two-flop synchronisers on every host pin.
        next_r.rts_s = {r.rts_s[0], pins.rts_n};
        next_r.bds_s = {r.bds_s[0], pins.baud_default_select};
        next_r.wp_s = {r.wp_s[0], pins.nvm_write_permit};
        next_r.rst_s = {r.rst_s[0], pins.ctrl_reset};

        // Handshake and memory write decisions on the synchronised pins.
        next_r.rdy = !r.rts_s[1] && !r.in_rst;
        next_r.cts_n = r.in_rst || !tx_space_in;
        next_r.wr = nvm_write_req_in && !r.wp_s[1] && !r.in_rst;
        next_r.blk = nvm_write_req_in && (r.wp_s[1] || r.in_rst);

        // The weak hold-low on the reset pin is registered like any output.
        next_r.pull_lo = 1'b0;
        next_r.pull_oe = 1'b1;

        case (r.state)
            hpc_pkg::HPC_COLD, hpc_pkg::HPC_WARM: begin
                next_r.in_rst = 1'b1;
                if (r.rst_s[1]) begin
                    // A pulse during recovery counts its first sample too.
                    next_r.state = hpc_pkg::HPC_RESET;
                    next_r.cnt = hpc_pkg::CNT_W'(1);
                end else if (r.cnt == '0) begin
                    // Sample the select pin as reset recovery ends.
                    next_r.state = hpc_pkg::HPC_RUN;
                    next_r.in_rst = 1'b0;
                    // Select low gives the fixed format, high the stored baud with the fixed 8-N-1 framing.
                    if (!r.bds_s[1]) begin
                        next_r.baud = hpc_pkg::DEFAULT_BAUD;
                        next_r.dbits = hpc_pkg::DEFAULT_DATA_BITS;
                        next_r.par = hpc_pkg::DEFAULT_PARITY;
                        next_r.stop = hpc_pkg::DEFAULT_STOP_BITS;
                    end else begin
                        next_r.baud = nvm_baud_in;
                        next_r.dbits = hpc_pkg::DEFAULT_DATA_BITS;
                        next_r.par = hpc_pkg::DEFAULT_PARITY;
                        next_r.stop = hpc_pkg::DEFAULT_STOP_BITS;
                    end
                end else begin
                    // Count the recovery down.
                    next_r.cnt = r.cnt - 1'b1;
                end
            end

            hpc_pkg::HPC_RUN: begin
                // The first high sample already counts toward the width.
                if (r.rst_s[1]) begin
                    next_r.state = hpc_pkg::HPC_RESET;
                    next_r.cnt = hpc_pkg::CNT_W'(1);
                end
            end

            hpc_pkg::HPC_RESET: begin
                // Count high samples until the least width is met.
                if (!pulse_ok) begin
                    next_r.cnt = r.cnt + 1'b1;
                end
                // Long enough: enter reset while the pin is still high.
                if (pulse_ok) begin
                    next_r.in_rst = 1'b1;
                end
                // The pin has fallen: choose what follows the pulse.
                if (!r.rst_s[1]) begin
                    if (pulse_ok) begin
                        next_r.state = hpc_pkg::HPC_WARM;
                        next_r.cnt = hpc_pkg::WARM_RECOVERY_CYC;
                    end else if (r.in_rst) begin
                        next_r.state = hpc_pkg::HPC_COLD;
                        next_r.cnt = hpc_pkg::COLD_RECOVERY_CYC;
                    end else begin
                        // A pulse shorter than the least width is ignored.
                        next_r.state = hpc_pkg::HPC_RUN;
                        next_r.cnt = '0;
                    end
                end
            end

            default: begin
                // An unused state code falls back to a cold recovery.
                next_r.state = hpc_pkg::HPC_COLD;
                next_r.cnt = hpc_pkg::COLD_RECOVERY_CYC;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            r <= '0;
            // Synchronisers start at the idle level of their pins, so no
            // false pin change is seen after reset.
            r.rts_s <= 2'h3;
            r.bds_s <= 2'h3;
            r.wp_s <= 2'h3;
            r.state <= hpc_pkg::HPC_COLD;
            r.cnt <= hpc_pkg::COLD_RECOVERY_CYC;
            r.cts_n <= 1'b1;
            r.in_rst <= 1'b1;
            r.pull_oe <= 1'b1;
            r.dbits <= hpc_pkg::DEFAULT_DATA_BITS;
            r.stop <= hpc_pkg::DEFAULT_STOP_BITS;
        end else begin
            r <= next_r;
        end
    end


    // Every output below comes straight from a register.
    assign pins.cts_n = r.cts_n;
    // Weak hold-low of the reset pin; a host drive overrides it.
    assign pins.ctrl_reset_dev = r.pull_lo;
    assign pins.ctrl_reset_dev_oe = r.pull_oe;
    assign nvm_write_out = r.wr;
    assign nvm_write_blocked_out = r.blk;
    assign host_ready_out = r.rdy;
    assign in_reset_out = r.in_rst;
    assign baud_out = r.baud;
    assign data_bits_out = r.dbits;
    assign parity_out = r.par;
    assign stop_bits_out = r.stop;
endmodule
`default_nettype wire

// ---- verilog/hpc_host.sv ----
// Host end of the transceiver control pins.
`default_nettype none
module hpc_host #(
    parameter int RESET_CYC = hpc_pkg::RESET_MIN_CYC
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    hpc_if.host pins,
    input wire logic rx_ready_in,
    input wire logic use_default_baud_in,
    input wire logic write_permit_in,
    input wire logic reset_req_in,
    output logic can_send_out,
    output logic reset_busy_out
);
    typedef struct packed {
        hpc_pkg::hpc_hstate_e state;
        logic [hpc_pkg::CNT_W-1:0] cnt;
        logic rts_n;
        logic bds;
        logic wp;
        logic rst;
        logic send;
        logic busy;
    } hpc_host_s;

    hpc_host_s r;
    hpc_host_s next_r;

    always_comb begin
        next_r = r;
        next_r.rts_n = !rx_ready_in;
        next_r.bds = !use_default_baud_in;
        next_r.send = !pins.cts_n;
        next_r.rst = 1'b0;
        case (r.state)
            hpc_pkg::HPC_H_IDLE: begin
                if (reset_req_in) begin
                    next_r.state = hpc_pkg::HPC_H_PULSE;
                    next_r.cnt = '0;
                    next_r.rst = 1'b1;
                end
            end
            hpc_pkg::HPC_H_PULSE: begin
                next_r.rst = 1'b1;
                next_r.cnt = r.cnt + 1'b1;
                if (r.cnt >= hpc_pkg::CNT_W'(RESET_CYC)) begin
                    next_r.state = hpc_pkg::HPC_H_IDLE;
                    next_r.rst = 1'b0;
                end
            end
            default: begin
                next_r.state = hpc_pkg::HPC_H_IDLE;
            end
        endcase
        // Permit stays high whenever a reset pulse is under way.
        next_r.wp = next_r.rst || !write_permit_in;
        next_r.busy = next_r.state == hpc_pkg::HPC_H_PULSE;
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            r <= '0;
            r.state <= hpc_pkg::HPC_H_IDLE;
            r.rts_n <= 1'b1;
            r.bds <= 1'b1;
            r.wp <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign pins.rts_n = r.rts_n;
    assign pins.baud_default_select = r.bds;
    assign pins.nvm_write_permit = r.wp;
    assign pins.ctrl_reset = r.rst;
    assign pins.ctrl_reset_oe = 1'b1;
    assign can_send_out = r.send;
    assign reset_busy_out = r.busy;
endmodule
`default_nettype wire

// ---- dv/hpc_monitor.sv ----
// Checker on the control pins between host and transceiver.
`default_nettype none
module hpc_monitor #(
    parameter int RESET_CYC = 50000
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic cts_n,
    input wire logic rts_n,
    input wire logic baud_default_select,
    input wire logic nvm_write_permit,
    input wire logic ctrl_reset,
    input wire logic ctrl_reset_oe,
    input wire logic ctrl_reset_dev,
    input wire logic ctrl_reset_dev_oe
);
    logic [16:0] high_cnt;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!arst_n_in);
    // Counts how long the reset pin has been high without a break.
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            high_cnt <= 17'h00000;
        end else begin
            high_cnt <= ctrl_reset ? high_cnt + 17'h00001 : 17'h00000;
        end
    end
    wp_in_reset_a: assert property (ctrl_reset |-> nvm_write_permit)
        else $error("write permit low during reset pulse");
    reset_idle_a: assert property
        (ctrl_reset |-> ctrl_reset_oe && high_cnt <= RESET_CYC)
        else $error("reset pin high outside a reset pulse");
    pull_low_a: assert property
        (ctrl_reset_dev_oe && !ctrl_reset_dev)
        else $error("reset pin hold-low missing");
    pulse_width_a: assert property
        ($fell(ctrl_reset) |-> high_cnt >= RESET_CYC)
        else $error("reset pulse too short");
    dev_reset_a: assert property ($fell(ctrl_reset) |-> ##[0:8] cts_n)
        else $error("device not in reset after pulse");
    warm_hold_a: assert property ($fell(ctrl_reset) |-> ##4 cts_n [*8])
        else $error("clear to send low during recovery");
    warm_done_a: assert property
        ($fell(ctrl_reset) |-> ##[1:60] !cts_n)
        else $error("warm recovery too long");
    host_init_a: assert property ($rose(arst_n_in) |-> rts_n &&
        baud_default_select && nvm_write_permit && !ctrl_reset)
        else $error("host pins wrong after reset");
    cold_cts_a: assert property ($rose(arst_n_in) |-> cts_n [*8])
        else $error("clear to send low during cold recovery");
endmodule
`default_nettype wire

// ---- dv/test_host_port_control_pins.sv ----
// Self-checking bench joining both ends of the control pins.
`default_nettype none
module test_host_port_control_pins;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic tx_space = 1'b1, nvm_req = 1'b0, rx_ready = 1'b0;
    logic use_dflt = 1'b1, permit = 1'b0, reset_req = 1'b0;
    logic [23:0] nvm_baud = 24'h01c200;
    logic nvm_write, nvm_blocked, host_ready, in_reset, can_send, busy;
    logic [23:0] baud;
    logic [3:0] data_bits;
    logic [1:0] parity, stop_bits;
    int error_cnt = 0;
    int num_checks = 0;
    int n;
    hpc_if u_hpc_if ();
    hpc_device u_hpc_device (.clk_in(clk_in), .arst_n_in(arst_n_in),
        .pins(u_hpc_if), .tx_space_in(tx_space), .nvm_write_req_in(nvm_req),
        .nvm_baud_in(nvm_baud), .nvm_write_out(nvm_write),
        .nvm_write_blocked_out(nvm_blocked), .host_ready_out(host_ready),
        .in_reset_out(in_reset), .baud_out(baud),
        .data_bits_out(data_bits), .parity_out(parity),
        .stop_bits_out(stop_bits));
    hpc_host #(.RESET_CYC(hpc_pkg::RESET_MIN_CYC)) u_hpc_host (
        .clk_in(clk_in), .arst_n_in(arst_n_in), .pins(u_hpc_if),
        .rx_ready_in(rx_ready), .use_default_baud_in(use_dflt),
        .write_permit_in(permit), .reset_req_in(reset_req),
        .can_send_out(can_send), .reset_busy_out(busy));
    hpc_monitor #(.RESET_CYC(hpc_pkg::RESET_MIN_CYC)) u_hpc_monitor (
        .clk_in(clk_in), .arst_n_in(arst_n_in), .cts_n(u_hpc_if.cts_n),
        .rts_n(u_hpc_if.rts_n),
        .baud_default_select(u_hpc_if.baud_default_select),
        .nvm_write_permit(u_hpc_if.nvm_write_permit),
        .ctrl_reset(u_hpc_if.ctrl_reset),
        .ctrl_reset_oe(u_hpc_if.ctrl_reset_oe),
        .ctrl_reset_dev(u_hpc_if.ctrl_reset_dev),
        .ctrl_reset_dev_oe(u_hpc_if.ctrl_reset_dev_oe));
    initial begin
        forever #20 clk_in = ~clk_in;
    end
    task conclude;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Waits one cycle of a bounded loop and gives up past the bound.
    task tick(input string what, input int bound);
        @(negedge clk_in);
        n++;
        if (n > bound) begin
            chk(what, 24'h000000, 24'hffffff);
            conclude();
        end
    endtask
    task s_cold;
        n = 0;
        while (in_reset !== 1'b0) tick("cold wait", 2000);
        chk("cold length", 1'b1, n >= 1024);
        chk("baud", hpc_pkg::DEFAULT_BAUD, baud);
        chk("bits", 4'h8, data_bits);
        chk("parity", 2'h0, parity);
        chk("stop", 2'h1, stop_bits);
        chk("pull level", 1'b0, u_hpc_if.ctrl_reset_dev);
        chk("pull enable", 1'b1, u_hpc_if.ctrl_reset_dev_oe);
    endtask
    task s_cts;
        tx_space = 1'b0;
        repeat (5) @(negedge clk_in);
        chk("cts full", 1'b1, u_hpc_if.cts_n);
        chk("send full", 1'b0, can_send);
        tx_space = 1'b1;
        repeat (5) @(negedge clk_in);
        chk("cts room", 1'b0, u_hpc_if.cts_n);
        chk("send room", 1'b1, can_send);
    endtask
    task s_rts;
        rx_ready = 1'b1;
        repeat (5) @(negedge clk_in);
        chk("rts ready", 1'b0, u_hpc_if.rts_n);
        chk("ready seen", 1'b1, host_ready);
        rx_ready = 1'b0;
        repeat (5) @(negedge clk_in);
        chk("ready gone", 1'b0, host_ready);
    endtask
    task s_nvm;
        nvm_req = 1'b1;
        repeat (5) @(negedge clk_in);
        chk("write shut", 1'b0, nvm_write);
        chk("blocked", 1'b1, nvm_blocked);
        permit = 1'b1;
        repeat (5) @(negedge clk_in);
        chk("write open", 1'b1, nvm_write);
        chk("unblocked", 1'b0, nvm_blocked);
        nvm_req = 1'b0;
    endtask
    task s_warm;
        use_dflt = 1'b0;
        reset_req = 1'b1;
        repeat (2) @(negedge clk_in);
        reset_req = 1'b0;
        repeat (100) @(negedge clk_in);
        chk("pulse pin", 1'b1, u_hpc_if.ctrl_reset);
        chk("permit pin", 1'b1, u_hpc_if.nvm_write_permit);
        chk("busy", 1'b1, busy);
        chk("not early", 1'b0, in_reset);
        n = 0;
        while (in_reset !== 1'b1) tick("reset wait", 50100);
        chk("pulse held", 1'b1, n > 49000);
        n = 0;
        while (u_hpc_if.ctrl_reset !== 1'b0) tick("pin wait", 100);
        n = 0;
        while (in_reset !== 1'b0) tick("warm wait", 200);
        chk("warm length", 1'b1, n < 1024);
        chk("nvm baud", 24'h01c200, baud);
        chk("warm bits", 4'h8, data_bits);
        permit = 1'b0;
    endtask
    initial begin
        repeat (8) @(negedge clk_in);
        arst_n_in = 1'b1;
        s_cold();
        s_cts();
        s_rts();
        s_nvm();
        s_warm();
        conclude();
    end
endmodule
`default_nettype wire
